/* File: logic/fdpc_pkg.sv */
// constants shared by the frequency and duty power control block
// assumes a single 10 MHz clock and an external current sense word in mA
package fdpc_pkg;

	// ----------------------------------------------------------------
	// clock and loop timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 32'h0098_9680;
	localparam int unsigned CLK_PERIOD_NS = 32'h0000_0064;
	// one controller update per current sample, taken as 1 ms apart
	localparam int unsigned LOOP_PERIOD_MS = 32'h0000_0001;
	localparam int unsigned LOOP_PERIOD_CYCLES = (LOOP_PERIOD_MS * CLK_HZ) / 32'h0000_03e8;

	// ----------------------------------------------------------------
	// frequency range and bands, in Hz
	// ----------------------------------------------------------------
	localparam int FREQ_W = 18;
	localparam logic [17:0] FREQ_MIN_HZ = 18'h1adb0;
	localparam logic [17:0] FREQ_MAX_HZ = 18'h320c8;
	localparam logic [17:0] FREQ_PING_HZ = 18'h2ab98;
	localparam logic [17:0] BAND1_TOP_HZ = 18'h222e0;
	localparam logic [17:0] BAND2_TOP_HZ = 18'h27100;
	localparam logic [17:0] BAND3_TOP_HZ = 18'h2bf20;
	// scale factor per band, in half hertz per unit of loop output
	localparam logic [3:0] SCALE_B1_HALF_HZ = 4'h3;
	localparam logic [3:0] SCALE_B2_HALF_HZ = 4'h4;
	localparam logic [3:0] SCALE_B3_HALF_HZ = 4'h6;
	localparam logic [3:0] SCALE_B4_HALF_HZ = 4'ha;

	// ----------------------------------------------------------------
	// duty cycle in units of 0.1 percent
	// ----------------------------------------------------------------
	localparam int DUTY_W = 10;
	localparam logic [9:0] DUTY_MIN = 10'h064;
	localparam logic [9:0] DUTY_MAX = 10'h1f4;
	localparam logic [9:0] DUTY_PING = 10'h1f4;
	localparam logic [9:0] PHASE_FULL = 10'h3e8;
	// loop output times -0.01 percent equals loop output over ten units
	localparam logic [4:0] DUTY_SCALE_DIV = 5'h0a;

	// ----------------------------------------------------------------
	// controller gains and limits
	// ----------------------------------------------------------------
	localparam logic signed [7:0] KP = 8'sh0a;
	localparam logic signed [7:0] KD = 8'sh00;
	// integral gain 0.05 is one over this divisor
	localparam logic signed [7:0] KI_DIV = 8'sh14;
	localparam logic signed [23:0] ITERM_LIMIT = 24'sh000bb8;
	localparam logic signed [23:0] ISUM_LIMIT = 24'sh00ea60;
	localparam logic signed [23:0] OUT_LIMIT = 24'sh004e20;

	// ----------------------------------------------------------------
	// phase accumulator: increment = freq * 2^48 / CLK_HZ >> 16
	// ----------------------------------------------------------------
	localparam logic [24:0] INC_MUL = 25'h1ad7f2a;
	localparam int INC_SHIFT = 16;

	typedef enum logic [2:0] {
		FDPC_IDLE,
		FDPC_PING,
		FDPC_WAIT,
		FDPC_CALC,
		FDPC_APPLY
	} fdpc_state_t;

endpackage : fdpc_pkg

/* File: logic/fdpc_pid.sv */
// loop controller: proportional, clamped integral and derivative terms
// assumes start pulses from the same clock, one error value per start
`timescale 1ns/100ps
module fdpc_pid (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic start,
	input wire logic signed [16:0] errIn,
	output logic signed [15:0] loopOut,
	output logic outValid
);
	import fdpc_pkg::*;

	logic signed [23:0] iSum_q;
	logic signed [23:0] iSum_d;
	logic signed [23:0] errPrev_q;
	logic signed [23:0] err;
	logic signed [23:0] iTerm;
	logic signed [23:0] total;

	// ----------------------------------------------------------------
	// term arithmetic
	// ----------------------------------------------------------------
	always_comb begin
		err = 24'(errIn);
		iSum_d = iSum_q + err;
		if (iSum_d > ISUM_LIMIT) begin
			iSum_d = ISUM_LIMIT;
		end else if (iSum_d < -ISUM_LIMIT) begin
			iSum_d = -ISUM_LIMIT;
		end
		iTerm = iSum_d / 24'(KI_DIV);
		if (iTerm > ITERM_LIMIT) begin
			iTerm = ITERM_LIMIT;
		end else if (iTerm < -ITERM_LIMIT) begin
			iTerm = -ITERM_LIMIT;
		end
		total = 24'(KP * err) + iTerm + 24'(KD * (err - errPrev_q));
		if (total > OUT_LIMIT) begin
			total = OUT_LIMIT;
		end else if (total < -OUT_LIMIT) begin
			total = -OUT_LIMIT;
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			iSum_q <= '0;
			errPrev_q <= '0;
		end else if (clear) begin
			iSum_q <= '0;
			errPrev_q <= '0;
		end else if (start) begin
			iSum_q <= iSum_d;
			errPrev_q <= err;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			loopOut <= '0;
			outValid <= 1'b0;
		end else begin
			outValid <= start & ~clear;
			if (start & ~clear) begin
				loopOut <= 16'(total);
			end
		end
	end

endmodule : fdpc_pid

/* File: logic/fdpc_pwm.sv */
// full-bridge drive from a phase accumulator with 0.1 percent duty steps
// assumes increment and duty come from registers on the same clock
`timescale 1ns/100ps
module fdpc_pwm (
	input wire logic clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic [31:0] incWord,
	input wire logic [9:0] duty,
	output logic drivePos,
	output logic driveNeg
);
	import fdpc_pkg::*;

	logic [31:0] phase_q;
	logic [32:0] phaseSum;
	logic [31:0] incLive_q;
	logic [9:0] dutyLive_q;
	logic [21:0] fracProd;
	logic [9:0] phaseFrac;

	assign phaseSum = {1'b0, phase_q} + {1'b0, incLive_q};
	assign fracProd = phase_q[31:20] * PHASE_FULL;
	assign phaseFrac = fracProd[21:12];

	// ----------------------------------------------------------------
	// accumulator; new settings take effect at a period boundary, or every cycle while disabled
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= '0;
			incLive_q <= '0;
			dutyLive_q <= '0;
		end else if (!enable) begin
			phase_q <= '0;
			incLive_q <= incWord;
			dutyLive_q <= duty;
		end else begin
			phase_q <= phaseSum[31:0];
			if (phaseSum[32]) begin
				incLive_q <= incWord;
				dutyLive_q <= duty;
			end
		end
	end

	// ----------------------------------------------------------------
	// positive leg in first half, negative leg in second half
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drivePos <= 1'b0;
			driveNeg <= 1'b0;
		end else begin
			drivePos <= enable && (phaseFrac < dutyLive_q);
			driveNeg <= enable && (phaseFrac >= DUTY_MAX) && ((phaseFrac - DUTY_MAX) < dutyLive_q);
		end
	end

endmodule : fdpc_pwm

/* File: logic/fdpc_top.sv */
// frequency and duty power control for a full-bridge coil driver
// assumes current sample words in mA from same-clock logic, with a strobe
//
// Functional notes
// - frequency mode spans 110 to 205 kHz, 50% duty
// - duty varies only at 205 kHz, within 10-50%
// - less power: higher frequency or lower duty
// - fine frequency steps from 110 to 175 kHz
// - fine frequency steps from 175 to 205 kHz
// - duty steps of 0.1 percent or finer
// - ping starts at 175 kHz, 50% duty
// - loop controller drives frequency or duty
// - coil current feedback at 7 mA or finer
// - gains 10, 0.05, 0; limits 3000, 20000
// - frequency scale 1.5, 2, 3, 5 by band
// - duty scale -0.01 with same gains, limits
`timescale 1ns/100ps
module fdpc_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic powerEnable,
	input wire logic sampleValid,
	input wire logic [15:0] targetCurrent,
	input wire logic [15:0] coilCurrent,
	output logic drivePos,
	output logic driveNeg,
	output logic [fdpc_pkg::FREQ_W-1:0] switchingFrequency,
	output logic [fdpc_pkg::DUTY_W-1:0] dutyCycle,
	output logic dutyMode,
	output logic limitHit,
	output logic updateDone
);
	import fdpc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	fdpc_state_t state_q;
	logic [17:0] freq_q;
	logic [17:0] freq_d;
	logic [9:0] duty_q;
	logic [9:0] duty_d;
	logic dutyMode_q;
	logic dutyMode_d;
	logic sat_d;
	logic running_q;
	logic [31:0] incWord_q;
	logic [42:0] incProd;
	logic signed [16:0] err_q;
	logic pidStart;
	logic pidClear;
	logic signed [15:0] pidOut;
	logic pidValid;
	logic signed [23:0] freqStep;
	logic signed [23:0] freqNew;
	logic signed [23:0] dutyStep;
	logic signed [23:0] dutyNew;
	logic pidStartLate;
	logic [17:0] freqCand;
	logic freqAtTop;
	logic freqAtFloor;
	logic [9:0] dutyCand;
	logic dutyAtTop;
	logic dutyAtFloor;

	// ----------------------------------------------------------------
	// band scale, half hertz per unit of loop output
	// ----------------------------------------------------------------
	function automatic logic [3:0] bandScale(input logic [17:0] f);
		if (f < BAND1_TOP_HZ) begin
			bandScale = SCALE_B1_HALF_HZ;
		end else if (f < BAND2_TOP_HZ) begin
			bandScale = SCALE_B2_HALF_HZ;
		end else if (f < BAND3_TOP_HZ) begin
			bandScale = SCALE_B3_HALF_HZ;
		end else begin
			bandScale = SCALE_B4_HALF_HZ;
		end
	endfunction : bandScale

	// ----------------------------------------------------------------
	// control sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= FDPC_IDLE;
		end else if (!powerEnable) begin
			state_q <= FDPC_IDLE;
		end else begin
			case (state_q)
				FDPC_IDLE: begin
					state_q <= FDPC_PING;
				end
				FDPC_PING: begin
					state_q <= FDPC_WAIT;
				end
				FDPC_WAIT: begin
					if (sampleValid) begin
						state_q <= FDPC_CALC;
					end
				end
				FDPC_CALC: begin
					if (pidValid) begin
						state_q <= FDPC_APPLY;
					end
				end
				FDPC_APPLY: begin
					state_q <= FDPC_WAIT;
				end
				default: begin
					state_q <= FDPC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// controller handshake
	// ----------------------------------------------------------------
	// controller cleared at ping and whenever the controlled variable changes
	assign pidClear = (state_q == FDPC_PING) || (state_q == FDPC_IDLE)
		|| ((state_q == FDPC_APPLY) && (dutyMode_d != dutyMode_q));
	assign pidStart = (state_q == FDPC_WAIT) && sampleValid && powerEnable;

	// start the controller one cycle after the error is latched
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pidStartLate <= 1'b0;
		end else begin
			pidStartLate <= pidStart;
		end
	end

	// ----------------------------------------------------------------
	// current error, sampled while waiting
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			err_q <= '0;
		end else if ((state_q == FDPC_WAIT) && sampleValid) begin
			err_q <= $signed({1'b0, targetCurrent}) - $signed({1'b0, coilCurrent});
		end
	end

	fdpc_pid pidUnit (
		.clk(clk),
		.resetn(resetn),
		.clear(pidClear),
		.start(pidStartLate),
		.errIn(err_q),
		.loopOut(pidOut),
		.outValid(pidValid)
	);

	// ----------------------------------------------------------------
	// loop output to setpoint steps
	// ----------------------------------------------------------------
	always_comb begin
		// signed operands keep negative outputs from wrapping
		freqStep = (24'(pidOut) * $signed(24'(bandScale(freq_q)))) / 24'sd2;
		freqNew = $signed(24'(freq_q)) - freqStep;
		dutyStep = 24'(pidOut) / $signed(24'(DUTY_SCALE_DIV));
		dutyNew = $signed(24'(duty_q)) + dutyStep;
	end

	// ----------------------------------------------------------------
	// frequency candidate, saturated at the range edges
	// ----------------------------------------------------------------
	always_comb begin
		// signed compare: a large positive step must not look like the top
		freqAtTop = (freqNew >= $signed(24'(FREQ_MAX_HZ)));
		freqAtFloor = (freqNew <= $signed(24'(FREQ_MIN_HZ)));
		if (freqAtTop) begin
			freqCand = FREQ_MAX_HZ;
		end else if (freqAtFloor) begin
			freqCand = FREQ_MIN_HZ;
		end else begin
			freqCand = 18'(freqNew);
		end
	end

	// ----------------------------------------------------------------
	// duty candidate, saturated at the duty limits
	// ----------------------------------------------------------------
	always_comb begin
		// duty below zero would otherwise compare as a huge value
		dutyAtTop = (dutyNew >= $signed(24'(DUTY_MAX)));
		dutyAtFloor = (dutyNew <= $signed(24'(DUTY_MIN)));
		if (dutyAtTop) begin
			dutyCand = DUTY_MAX;
		end else if (dutyAtFloor) begin
			dutyCand = DUTY_MIN;
		end else begin
			dutyCand = 10'(dutyNew);
		end
	end

	// ----------------------------------------------------------------
	// setpoint and mode selection
	// ----------------------------------------------------------------
	always_comb begin
		freq_d = freq_q;
		duty_d = duty_q;
		dutyMode_d = dutyMode_q;
		sat_d = 1'b0;
		if (!dutyMode_q) begin
			freq_d = freqCand;
			duty_d = DUTY_MAX;
			dutyMode_d = freqAtTop;
			sat_d = freqAtTop || freqAtFloor;
		end else begin
			freq_d = FREQ_MAX_HZ;
			duty_d = dutyCand;
			// back to frequency control once duty is at half again
			dutyMode_d = !dutyAtTop;
			sat_d = dutyAtTop || dutyAtFloor;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			freq_q <= FREQ_PING_HZ;
			duty_q <= DUTY_PING;
			dutyMode_q <= 1'b0;
		end else if (state_q == FDPC_PING) begin
			freq_q <= FREQ_PING_HZ;
			duty_q <= DUTY_PING;
			dutyMode_q <= 1'b0;
		end else if (state_q == FDPC_APPLY) begin
			freq_q <= freq_d;
			duty_q <= duty_d;
			dutyMode_q <= dutyMode_d;
		end
	end

	// saturation flag, cleared by a new ping
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			limitHit <= 1'b0;
		end else if (state_q == FDPC_PING) begin
			limitHit <= 1'b0;
		end else if (state_q == FDPC_APPLY) begin
			limitHit <= sat_d;
		end
	end

	// ----------------------------------------------------------------
	// drive enable and handshake
	// ----------------------------------------------------------------
	// drive runs from the cycle after the ping state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			running_q <= 1'b0;
		end else begin
			running_q <= powerEnable && (state_q != FDPC_IDLE);
		end
	end

	// one pulse per applied update
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			updateDone <= 1'b0;
		end else begin
			updateDone <= (state_q == FDPC_APPLY);
		end
	end

	// ----------------------------------------------------------------
	// frequency to accumulator increment, about 0.0023 Hz per step
	// ----------------------------------------------------------------
	assign incProd = freq_q * INC_MUL;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			incWord_q <= '0;
		end else begin
			incWord_q <= 32'(incProd >> INC_SHIFT);
		end
	end

	fdpc_pwm bridge (
		.clk(clk),
		.resetn(resetn),
		.enable(running_q),
		.incWord(incWord_q),
		.duty(duty_q),
		.drivePos(drivePos),
		.driveNeg(driveNeg)
	);

	// ----------------------------------------------------------------
	// status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			switchingFrequency <= FREQ_PING_HZ;
			dutyCycle <= DUTY_PING;
			dutyMode <= 1'b0;
		end else begin
			switchingFrequency <= freq_q;
			dutyCycle <= duty_q;
			dutyMode <= dutyMode_q;
		end
	end

endmodule : fdpc_top

/* File: test/fdpc_top_sva.sv */
// checker for the frequency and duty power control top
// assumes binding to fdpc_top, sees its ports only
`timescale 1ns/100ps
module fdpc_top_sva (
	input wire logic clk,
	input wire logic resetn,
	input wire logic powerEnable,
	input wire logic sampleValid,
	input wire logic [15:0] targetCurrent,
	input wire logic [15:0] coilCurrent,
	input wire logic drivePos,
	input wire logic driveNeg,
	input wire logic [fdpc_pkg::FREQ_W-1:0] switchingFrequency,
	input wire logic [fdpc_pkg::DUTY_W-1:0] dutyCycle,
	input wire logic dutyMode,
	input wire logic updateDone
);
	import fdpc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_noOverlap; !(drivePos && driveNeg); endproperty
	a_noOverlap: assert property (p_noOverlap) else $error("both legs on");
	property p_freqRange;
		switchingFrequency >= FREQ_MIN_HZ && switchingFrequency <= FREQ_MAX_HZ;
	endproperty
	a_freqRange: assert property (p_freqRange) else $error("frequency out of range");
	property p_dutyRange; dutyCycle >= DUTY_MIN && dutyCycle <= DUTY_MAX; endproperty
	a_dutyRange: assert property (p_dutyRange) else $error("duty out of range");
	property p_freqModeDuty; !dutyMode |-> dutyCycle == DUTY_MAX; endproperty
	a_freqModeDuty: assert property (p_freqModeDuty) else $error("duty not half");
	property p_dutyModeFreq; dutyMode |-> switchingFrequency == FREQ_MAX_HZ; endproperty
	a_dutyModeFreq: assert property (p_dutyModeFreq) else $error("duty mode off top");
	property p_updLatency; updateDone |-> $past(sampleValid, 4); endproperty
	a_updLatency: assert property (p_updLatency) else $error("update without sample");
	property p_doneOnce; updateDone |=> !updateDone; endproperty
	a_doneOnce: assert property (p_doneOnce) else $error("update pulse too long");
	property p_pingStart;
		$rose(powerEnable) |-> ##[1:3] (switchingFrequency == FREQ_PING_HZ &&
			dutyCycle == DUTY_PING);
	endproperty
	a_pingStart: assert property (p_pingStart) else $error("ping setpoint wrong");
	property p_driveOff; !powerEnable [*3] |-> !drivePos && !driveNeg; endproperty
	a_driveOff: assert property (p_driveOff) else $error("drive while off");
	property p_stepDir;
		updateDone && !dutyMode && !$past(dutyMode) &&
			$past(targetCurrent, 4) > $past(coilCurrent, 4) |=>
			switchingFrequency <= $past(switchingFrequency);
	endproperty
	a_stepDir: assert property (p_stepDir) else $error("frequency rose on demand");
endmodule : fdpc_top_sva
bind fdpc_top fdpc_top_sva u_fdpc_top_sva (.clk(clk), .resetn(resetn),
	.powerEnable(powerEnable), .sampleValid(sampleValid), .targetCurrent(targetCurrent),
	.coilCurrent(coilCurrent), .drivePos(drivePos), .driveNeg(driveNeg),
	.switchingFrequency(switchingFrequency), .dutyCycle(dutyCycle), .dutyMode(dutyMode),
	.updateDone(updateDone));

/* File: test/fdpc_coil.sv */
// coil current sense model: one sample word per request
// assumes requests from the bench on the system clock
`timescale 1ns/100ps
module fdpc_coil (
	input wire logic clk,
	input wire logic resetn,
	input wire logic senseFire,
	input wire logic [15:0] senseLevel,
	output logic sampleValid,
	output logic [15:0] coilCurrent
);
	// word is scrambled between samples
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sampleValid <= 1'b0;
			coilCurrent <= 16'h0000;
		end else begin
			sampleValid <= senseFire;
			coilCurrent <= senseFire ? senseLevel : ~coilCurrent;
		end
	end
endmodule : fdpc_coil

/* File: test/fdpc_top_tb.sv */
// self-checking bench for the frequency and duty power control top
// assumes the coil sense model and the bound checker
`timescale 1ns/100ps
module fdpc_top_tb;
	import fdpc_pkg::*;
	logic clk, resetn, powerEnable, senseFire, sampleValid;
	logic [15:0] targetCurrent, senseLevel, coilCurrent;
	logic drivePos, driveNeg, dutyMode, limitHit, updateDone;
	logic [FREQ_W-1:0] switchingFrequency;
	logic [DUTY_W-1:0] dutyCycle;
	int n_fail, check_count, mSum, mFreq, mDuty, mMode;
	fdpc_top u_fdpc_top (.clk(clk), .resetn(resetn), .powerEnable(powerEnable),
		.sampleValid(sampleValid), .targetCurrent(targetCurrent), .coilCurrent(coilCurrent),
		.drivePos(drivePos), .driveNeg(driveNeg), .switchingFrequency(switchingFrequency),
		.dutyCycle(dutyCycle), .dutyMode(dutyMode), .limitHit(limitHit),
		.updateDone(updateDone));
	fdpc_coil u_fdpc_coil (.clk(clk), .resetn(resetn), .senseFire(senseFire),
		.senseLevel(senseLevel), .sampleValid(sampleValid), .coilCurrent(coilCurrent));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_near(input int got, input int exp, input int tol);
		check_count++;
		if (got > exp + tol || got < exp - tol) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_near
	function automatic int clamp(input int v, input int lim);
		return v > lim ? lim : (v < -lim ? -lim : v);
	endfunction : clamp
	// one sample, wait for the update, then mirror the loop arithmetic
	task automatic step(input int e);
		int s, pid, k;
		targetCurrent = 16'h0bb8;
		senseLevel = 16'(3000 - e);
		senseFire = 1'b1;
		tick(1);
		senseFire = 1'b0;
		for (k = 0; k < 20 && updateDone !== 1'b1; k++) tick(1);
		if (k == 20) begin
			n_fail++;
			test_done();
		end
		mSum = clamp(mSum + e, int'(ISUM_LIMIT));
		pid = int'(KP) * e + clamp(mSum / int'(KI_DIV), int'(ITERM_LIMIT));
		pid = clamp(pid, int'(OUT_LIMIT));
		if (mMode == 0) begin
			s = mFreq < int'(BAND1_TOP_HZ) ? 3 : mFreq < int'(BAND2_TOP_HZ) ? 4 :
				mFreq < int'(BAND3_TOP_HZ) ? 6 : 10;
			mFreq = mFreq - pid * s / 2;
			if (mFreq >= int'(FREQ_MAX_HZ)) begin
				mFreq = int'(FREQ_MAX_HZ);
				mMode = 1;
				mSum = 0;
			end else if (mFreq < int'(FREQ_MIN_HZ)) mFreq = int'(FREQ_MIN_HZ);
		end else begin
			mDuty = mDuty + pid / 10;
			if (mDuty >= 500) begin
				mDuty = 500;
				mMode = 0;
				mSum = 0;
			end else if (mDuty < 100) mDuty = 100;
		end
		// status outputs follow the update pulse by one cycle
		tick(1);
		chk(32'(switchingFrequency), mFreq);
		chk(32'(dutyCycle), mDuty);
		chk(32'(dutyMode), mMode);
		tick(1);
	endtask : step
	// period and high time over eight drive periods
	task automatic measure(input int freq, input int duty);
		int k, n, per, hi, hiNeg;
		logic prev;
		n = 0;
		per = 0;
		hi = 0;
		hiNeg = 0;
		prev = 1'b1;
		tick(100);
		for (k = 0; k < 3000 && n < 9; k++) begin
			tick(1);
			if (drivePos === 1'b1 && prev === 1'b0) n++;
			if (n > 0 && n < 9) per++;
			if (n > 0 && n < 9 && drivePos === 1'b1) hi++;
			if (n > 0 && n < 9 && driveNeg === 1'b1) hiNeg++;
			prev = drivePos;
		end
		chk_near(per, 80000000 / freq, 2);
		chk_near(hi, 80000 * duty / freq, 4);
		chk_near(hiNeg, 80000 * duty / freq, 4);
	endtask : measure
	task automatic t_reset_vals;
		chk(32'(switchingFrequency), 32'(FREQ_PING_HZ));
		chk(32'(dutyCycle), 32'(DUTY_PING));
		chk({30'h0, drivePos, driveNeg}, 32'h0);
	endtask : t_reset_vals
	task automatic t_refused;
		int k;
		senseFire = 1'b1;
		tick(1);
		senseFire = 1'b0;
		for (k = 0; k < 10; k++) begin
			tick(1);
			chk(32'(updateDone), 32'h0);
		end
	endtask : t_refused
	task automatic t_ping;
		powerEnable = 1'b1;
		mFreq = int'(FREQ_PING_HZ);
		mDuty = 500;
		mMode = 0;
		mSum = 0;
		tick(3);
		chk(32'(switchingFrequency), 32'h0002_ab98);
		chk(32'(dutyCycle), 32'h0000_01f4);
		measure(mFreq, 500);
	endtask : t_ping
	task automatic t_freq_bands;
		step(100);
		step(1);
		step(2000);
		step(1);
		step(-2000);
		step(-1000);
		step(-1000);
		step(-10);
		measure(mFreq, 500);
	endtask : t_freq_bands
	task automatic t_duty_mode;
		step(-2000);
		chk(32'(switchingFrequency), 32'(FREQ_MAX_HZ));
		step(-100);
		step(-1);
		measure(int'(FREQ_MAX_HZ), mDuty);
		step(-2000);
		chk(32'(limitHit), 32'h1);
		step(2000);
	endtask : t_duty_mode
	task automatic t_stop;
		powerEnable = 1'b0;
		tick(3);
		chk({30'h0, drivePos, driveNeg}, 32'h0);
		tick(5);
		t_ping();
		step(100);
	endtask : t_stop
	initial begin
		resetn = 1'b0;
		powerEnable = 1'b0;
		senseFire = 1'b0;
		senseLevel = 16'h0000;
		targetCurrent = 16'h0000;
		n_fail = 0;
		check_count = 0;
		tick(6);
		resetn = 1'b1;
		t_reset_vals();
		t_refused();
		t_ping();
		t_freq_bands();
		t_duty_mode();
		t_stop();
		test_done();
	end
endmodule : fdpc_top_tb
